// ===== hw/tsa_temp_sensor_port.sv
`timescale 1ns/100ps
// What this block does
// - Command bit 6: one reads, zero writes.
// - Command bits 5:3 address one register.
// - Write data, 8 or 16 bits, rising edge.
// - Read data driven from first following falling edge.
// - Select as frame sync, or tied low.
// - Thirty-two ones reset the port to command.
// - That reset also restores every register default.
// - Comparator and interrupt modes; interrupt after power-up.
// - Limit alert on above upper, below lower.
// - Comparator release uses hysteresis on both limits.
// - Comparator mode: shutdown keeps alert state.
// - Interrupt mode: any register read clears alert.
// - Interrupt mode: reassert only on new event.
// - Interrupt mode: shutdown clears the alert.
// - Shift out on falling, sample on rising.
// - Hysteresis is 4-bit degrees, default five.
module tsa_temp_sensor_port #(
    parameter logic [7:0] IDENT_VALUE = 8'h5a  // Arbitrary identification value.
) (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        sclkPin,
    input  wire logic        csPinN,
    input  wire logic        dinPin,
    output logic             doutOut,
    output logic             doutOe,
    input  wire logic [15:0] measuredTemp,
    input  wire logic        tempValid,
    input  wire logic        limitAlertIn,
    output logic             limitAlertOut,
    output logic             limitAlertOe,
    input  wire logic        criticalAlertPinIn,
    output logic             criticalAlertPinOut,
    output logic             criticalAlertPinOe
);
    localparam int W = tsa_pkg::WORD_W;

    logic [2:0]  pinLevel;
    logic [2:0]  pinRise;
    logic [2:0]  pinFall;
    logic        sclkRise;
    logic        sclkFall;
    logic        dinLevel;
    logic        selected;

    tsa_pkg::tsa_state_t stateQ;
    logic [4:0]  bitCntQ;
    logic [15:0] shiftInQ;
    logic [15:0] shiftOutQ;
    logic [2:0]  addrQ;
    logic [5:0]  onesQ;
    logic        portReset;
    logic        readPulse;
    logic [7:0]  cmdByte;
    logic [4:0]  lastBit;

    logic        pendValidQ;
    logic [W-1:0] pendWordQ;
    logic        fifoInReady;
    logic [W-1:0] fifoOutData;
    logic        fifoOutValid;
    logic        fifoOutReady;

    logic [7:0]  configQ;
    logic [15:0] critQ;
    logic [7:0]  hystQ;
    logic [15:0] upperQ;
    logic [15:0] lowerQ;
    logic [15:0] tempQ;
    logic [15:0] readValue;
    logic        regReset;
    logic        shutdown;
    logic        compMode;
    logic [15:0] hystScaled;
    logic [1:0]  alertActive;
    logic [1:0]  alertPol;
    logic [1:0]  condHit;
    logic [1:0]  condClear;
    logic [1:0]  alertOeQ;

    tsa_pin_sync #(
        .WIDTH     (3),
        .RESET_LVL (3'b011)
    ) uPinSync (
        .core_clk (core_clk),
        .reset    (reset),
        .pinIn    ({dinPin, csPinN, sclkPin}),
        .level    (pinLevel),
        .rise     (pinRise),
        .fall     (pinFall)
    );

    assign sclkRise = pinRise[0];
    assign sclkFall = pinFall[0];
    assign selected = ~pinLevel[1];
    assign dinLevel = pinLevel[2];
    assign cmdByte  = {shiftInQ[6:0], dinLevel};
    assign lastBit  = tsa_pkg::isWide(addrQ) ? tsa_pkg::LAST_WORD : tsa_pkg::LAST_BYTE;

    // Ones are counted on every rising clock edge, selected or not, so a
    // lost master can always recover the port.
    always_ff @(posedge core_clk) begin
        if (reset || portReset) begin
            onesQ <= '0;
        end else if (sclkRise) begin
            onesQ <= dinLevel ? onesQ + 1'b1 : '0;
        end
    end

    assign portReset = sclkRise && dinLevel && (onesQ == tsa_pkg::ONES_LAST);
    assign regReset  = reset || portReset;

    // Command and data framing; samples taken on rising edges.
    always_ff @(posedge core_clk) begin
        if (reset || portReset || !selected) begin
            stateQ  <= tsa_pkg::ST_CMD;
            bitCntQ <= '0;
        end else if (sclkRise) begin
            case (stateQ)
                tsa_pkg::ST_CMD: begin
                    if (bitCntQ == tsa_pkg::CMD_LAST) begin
                        bitCntQ <= '0;
                        if (cmdByte[tsa_pkg::CMD_RW_BIT]) begin
                            stateQ <= tsa_pkg::ST_RDATA;
                        end else begin
                            stateQ <= tsa_pkg::ST_WDATA;
                        end
                    end else begin
                        bitCntQ <= bitCntQ + 1'b1;
                    end
                end
                tsa_pkg::ST_WDATA, tsa_pkg::ST_RDATA: begin
                    // Returning to command after the last bit lets a master with
                    // select tied low run back-to-back frames.
                    if (bitCntQ == lastBit) begin
                        bitCntQ <= '0;
                        stateQ  <= tsa_pkg::ST_CMD;
                    end else begin
                        bitCntQ <= bitCntQ + 1'b1;
                    end
                end
                default: begin
                    stateQ  <= tsa_pkg::ST_CMD;
                    bitCntQ <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            shiftInQ <= '0;
        end else if (selected && sclkRise) begin
            shiftInQ <= {shiftInQ[14:0], dinLevel};
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            addrQ <= '0;
        end else if (selected && sclkRise && stateQ == tsa_pkg::ST_CMD &&
                     bitCntQ == tsa_pkg::CMD_LAST) begin
            addrQ <= cmdByte[tsa_pkg::CMD_ADDR_LSB +: 3];
        end
    end

    assign readPulse = selected && sclkRise && !portReset &&
                       stateQ == tsa_pkg::ST_CMD && bitCntQ == tsa_pkg::CMD_LAST &&
                       cmdByte[tsa_pkg::CMD_RW_BIT];

    // Read data is latched as the command ends, so a register write
    // draining from the queue cannot tear the word being shifted out.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            shiftOutQ <= '0;
            doutOut   <= 1'b0;
        end else if (readPulse) begin
            shiftOutQ <= readValue;
        end else if (sclkFall && stateQ == tsa_pkg::ST_RDATA) begin
            doutOut   <= shiftOutQ[15];
            shiftOutQ <= {shiftOutQ[14:0], 1'b0};
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            doutOe <= 1'b0;
        end else begin
            doutOe <= selected;
        end
    end

    // A completed write word waits here until the queue accepts it.
    always_ff @(posedge core_clk) begin
        if (reset || portReset) begin
            pendValidQ <= 1'b0;
            pendWordQ  <= '0;
        end else if (selected && sclkRise && stateQ == tsa_pkg::ST_WDATA &&
                     bitCntQ == lastBit) begin
            pendValidQ <= 1'b1;
            pendWordQ  <= {addrQ, shiftInQ[14:0], dinLevel};
        end else if (fifoInReady) begin
            pendValidQ <= 1'b0;
        end
    end

    // Register updates are held off while a read is being shifted out.
    assign fifoOutReady = (stateQ != tsa_pkg::ST_RDATA);

    tsa_fifo #(
        .WIDTH (W),
        .DEPTH (tsa_pkg::FIFO_DEPTH)
    ) uWriteQueue (
        .core_clk (core_clk),
        .reset    (reset),
        .flush    (portReset),
        .inData   (pendWordQ),
        .inValid  (pendValidQ),
        .inReady  (fifoInReady),
        .outData  (fifoOutData),
        .outValid (fifoOutValid),
        .outReady (fifoOutReady)
    );

    // Register file. Configuration takes the low byte of its word; hysteresis keeps only bits 3:0.
    always_ff @(posedge core_clk) begin
        if (regReset) begin
            configQ <= tsa_pkg::CONFIG_RESET;
            critQ   <= tsa_pkg::CRIT_RESET;
            hystQ   <= tsa_pkg::HYST_RESET;
            upperQ  <= tsa_pkg::UPPER_RESET;
            lowerQ  <= tsa_pkg::LOWER_RESET;
        end else if (fifoOutValid && fifoOutReady) begin
            case (fifoOutData[W-1 -: 3])
                tsa_pkg::REG_CONFIG: configQ <= fifoOutData[7:0];
                tsa_pkg::REG_CRIT:   critQ   <= fifoOutData[15:0];
                tsa_pkg::REG_HYST:   hystQ   <= {4'h0, fifoOutData[3:0]};
                tsa_pkg::REG_UPPER:  upperQ  <= fifoOutData[15:0];
                tsa_pkg::REG_LOWER:  lowerQ  <= fifoOutData[15:0];
                default:             configQ <= configQ;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (regReset) begin
            tempQ <= tsa_pkg::TEMP_RESET;
        end else if (tempValid && !shutdown) begin
            tempQ <= measuredTemp;
        end
    end

    // Byte registers are left aligned so the shifter always starts at bit 15.
    always_comb begin
        case (cmdByte[tsa_pkg::CMD_ADDR_LSB +: 3])
            tsa_pkg::REG_STATUS: readValue = {6'h00, alertActive, 8'h00};
            tsa_pkg::REG_CONFIG: readValue = {configQ, 8'h00};
            tsa_pkg::REG_TEMP:   readValue = tempQ;
            tsa_pkg::REG_IDENT:  readValue = {IDENT_VALUE, 8'h00};
            tsa_pkg::REG_CRIT:   readValue = critQ;
            tsa_pkg::REG_HYST:   readValue = {hystQ, 8'h00};
            tsa_pkg::REG_UPPER:  readValue = upperQ;
            tsa_pkg::REG_LOWER:  readValue = lowerQ;
            default:             readValue = 16'h0000;
        endcase
    end

    assign shutdown   = (configQ[tsa_pkg::CFG_OP_LSB +: 2] == tsa_pkg::OP_SHUTDOWN);
    assign compMode   = configQ[tsa_pkg::CFG_MODE];
    assign hystScaled = 16'(hystQ[tsa_pkg::HYST_BITS-1:0]) << tsa_pkg::HYST_SHIFT;
    assign alertPol   = {configQ[tsa_pkg::CFG_POL_CRIT], configQ[tsa_pkg::CFG_POL_LIMIT]};

    // Channel 0 is the limit alert, channel 1 the critical alert.
    assign condHit[0]   = ($signed(measuredTemp) > $signed(upperQ)) ||
                          ($signed(measuredTemp) < $signed(lowerQ));
    assign condClear[0] = ($signed(measuredTemp) < $signed(upperQ - hystScaled)) &&
                          ($signed(measuredTemp) > $signed(lowerQ + hystScaled));
    assign condHit[1]   = $signed(measuredTemp) > $signed(critQ);
    assign condClear[1] = $signed(measuredTemp) < $signed(critQ - hystScaled);

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gAlert
            logic compQ;
            logic intQ;
            logic armedQ;
            logic sample;

            assign sample = tempValid && !shutdown;

            // Shutdown stops conversions, so the comparator state simply holds.
            always_ff @(posedge core_clk) begin
                if (regReset) begin
                    compQ <= 1'b0;
                end else if (sample && condHit[g]) begin
                    compQ <= 1'b1;
                end else if (sample && condClear[g]) begin
                    compQ <= 1'b0;
                end
            end

            // A new event needs a return past the hysteresis release point first.
            always_ff @(posedge core_clk) begin
                if (regReset) begin
                    armedQ <= 1'b1;
                end else if (sample && condHit[g] && armedQ) begin
                    armedQ <= 1'b0;
                end else if (sample && condClear[g]) begin
                    armedQ <= 1'b1;
                end
            end

            // A new event wins over a read arriving in the same cycle.
            always_ff @(posedge core_clk) begin
                if (regReset) begin
                    intQ <= 1'b0;
                end else if (sample && condHit[g] && armedQ) begin
                    intQ <= 1'b1;
                end else if (readPulse || shutdown) begin
                    intQ <= 1'b0;
                end
            end

            assign alertActive[g] = compMode ? compQ : intQ;

            // Open drain: low is pulled, high is left to the pull-up.
            always_ff @(posedge core_clk) begin
                if (reset) begin
                    alertOeQ[g] <= 1'b0;
                end else begin
                    alertOeQ[g] <= alertPol[g] ? ~alertActive[g] : alertActive[g];
                end
            end
        end
    endgenerate

    assign limitAlertOut       = 1'b0;
    assign limitAlertOe        = alertOeQ[0];
    assign criticalAlertPinOut = 1'b0;
    assign criticalAlertPinOe  = alertOeQ[1];

endmodule

// ===== hw/tsa_pkg.sv
package tsa_pkg;

    // Register addresses carried in the command byte.
    localparam logic [2:0] REG_STATUS = 3'h0;
    localparam logic [2:0] REG_CONFIG = 3'h1;
    localparam logic [2:0] REG_TEMP   = 3'h2;
    localparam logic [2:0] REG_IDENT  = 3'h3;
    localparam logic [2:0] REG_CRIT   = 3'h4;
    localparam logic [2:0] REG_HYST   = 3'h5;
    localparam logic [2:0] REG_UPPER  = 3'h6;
    localparam logic [2:0] REG_LOWER  = 3'h7;

    // Power-on values.
    localparam logic [7:0]  CONFIG_RESET = 8'h00;
    localparam logic [15:0] CRIT_RESET   = 16'h4980;
    localparam logic [7:0]  HYST_RESET   = 8'h05;
    localparam logic [15:0] UPPER_RESET  = 16'h2000;
    localparam logic [15:0] LOWER_RESET  = 16'h0500;
    localparam logic [15:0] TEMP_RESET   = 16'h0000;

    // Command byte layout.
    localparam int          CMD_RW_BIT   = 6;
    localparam int          CMD_ADDR_LSB = 3;
    localparam logic [4:0]  CMD_LAST     = 5'h07;
    localparam logic [4:0]  LAST_BYTE    = 5'h07;
    localparam logic [4:0]  LAST_WORD    = 5'h0f;

    // Serial port reset: run of ones on the data input.
    localparam logic [5:0]  ONES_LAST    = 6'h1f;

    // Configuration fields.
    localparam int          CFG_POL_CRIT  = 2;
    localparam int          CFG_POL_LIMIT = 3;
    localparam int          CFG_MODE      = 4;
    localparam int          CFG_OP_LSB    = 5;
    localparam logic [1:0]  OP_SHUTDOWN   = 2'h1;

    // Hysteresis field and its scaling to the 1/128 degree limit format.
    localparam int          HYST_BITS  = 4;
    localparam int          HYST_SHIFT = 7;

    // Write word queued for the register file: address plus data.
    localparam int          WORD_W     = 19;
    localparam int          FIFO_DEPTH = 8;

    typedef enum logic [1:0] {
        ST_CMD   = 2'b00,
        ST_WDATA = 2'b01,
        ST_RDATA = 2'b10
    } tsa_state_t;

    function automatic logic isWide(input logic [2:0] addr);
        isWide = (addr == REG_TEMP) || (addr == REG_CRIT) ||
                 (addr == REG_UPPER) || (addr == REG_LOWER);
    endfunction

endpackage

// ===== hw/tsa_pin_sync.sv
`timescale 1ns/100ps
module tsa_pin_sync #(
    parameter int               WIDTH     = 3,
    parameter logic [WIDTH-1:0] RESET_LVL = '0
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] s1Q;
    logic [WIDTH-1:0] s2Q;
    logic [WIDTH-1:0] s3Q;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            s1Q <= RESET_LVL;
            s2Q <= RESET_LVL;
            s3Q <= RESET_LVL;
        end else begin
            s1Q <= pinIn;
            s2Q <= s1Q;
            s3Q <= s2Q;
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : gBit
            // A change only counts once the two later stages agree.
            always_ff @(posedge core_clk) begin
                if (reset) begin
                    level[i] <= RESET_LVL[i];
                end else if (s2Q[i] == s3Q[i]) begin
                    level[i] <= s3Q[i];
                end
            end
            assign rise[i] = s2Q[i] & s3Q[i] & ~level[i];
            assign fall[i] = ~s2Q[i] & ~s3Q[i] & level[i];
        end
    endgenerate
endmodule

// ===== hw/tsa_fifo.sv
`timescale 1ns/100ps
module tsa_fifo #(
    parameter int WIDTH = 19,
    parameter int DEPTH = 8
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic             flush,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] memQ [DEPTH];
    logic [AW-1:0]    wrPtrQ;
    logic [AW-1:0]    rdPtrQ;
    logic [AW:0]      countQ;
    logic             doPush;
    logic             doPop;

    assign inReady  = (countQ != DEPTH[AW:0]);
    assign outValid = (countQ != '0);
    assign outData  = memQ[rdPtrQ];
    assign doPush   = inValid && inReady;
    assign doPop    = outValid && outReady;

    always_ff @(posedge core_clk) begin
        if (doPush) begin
            memQ[wrPtrQ] <= inData;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset || flush) begin
            wrPtrQ <= '0;
            rdPtrQ <= '0;
            countQ <= '0;
        end else begin
            if (doPush) begin
                wrPtrQ <= wrPtrQ + 1'b1;
            end
            if (doPop) begin
                rdPtrQ <= rdPtrQ + 1'b1;
            end
            if (doPush && !doPop) begin
                countQ <= countQ + 1'b1;
            end else if (doPop && !doPush) begin
                countQ <= countQ - 1'b1;
            end
        end
    end
endmodule

// ===== verif/tsa_temp_sensor_port_properties.sv
`timescale 1ns/100ps
module tsa_temp_sensor_port_properties (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic sclkPin,
    input  wire logic csPinN,
    input  wire logic doutOut,
    input  wire logic doutOe,
    input  wire logic tempValid,
    input  wire logic limitAlertOut,
    input  wire logic limitAlertOe,
    input  wire logic criticalAlertPinOut,
    input  wire logic criticalAlertPinOe
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    sequence s_deselected;
        csPinN [*8];
    endsequence

    // With select quiet, only a fresh sample may raise an alert pull.
    sequence s_sampled;
        $past(tempValid, 2) || $past(tempValid, 3);
    endsequence

    // A deselected pin must not let a stale data value wander.
    a_dout_idle_hold: assert property (s_deselected |=> $stable(doutOut))
        else $error("data out moved while deselected");
    a_dout_fall_only: assert property ($changed(doutOut) |-> !sclkPin)
        else $error("data out changed while serial clock high");
    a_oe_select: assert property ($fell(csPinN) |-> ##[3:6] doutOe)
        else $error("data out not enabled after select");
    a_oe_release: assert property ($rose(csPinN) |-> ##[3:6] !doutOe)
        else $error("data out still enabled after deselect");
    a_alert_low_drive: assert property (!limitAlertOut && !criticalAlertPinOut)
        else $error("alert pin driven high");
    a_limit_set_cause: assert property (
        $rose(limitAlertOe) && csPinN && $past(csPinN, 10) |-> s_sampled)
        else $error("limit alert rose without a sample");
    a_crit_set_cause: assert property (
        $rose(criticalAlertPinOe) && csPinN && $past(csPinN, 10) |-> s_sampled)
        else $error("critical alert rose without a sample");
    a_reset_quiet: assert property (@(posedge core_clk) disable iff (1'b0)
        reset |=> !doutOe && !limitAlertOe && !criticalAlertPinOe)
        else $error("outputs active after reset");
endmodule

// ===== verif/tsa_spi_master_model.sv
`timescale 1ns/100ps
module tsa_spi_master_model #(
    parameter int HALF      = 8,
    parameter int RESET_GAP = 64  // Much shorter than the real pause, to keep runs short.
) (
    input  wire logic core_clk,
    output logic      sclkPin,
    output logic      csPinN,
    output logic      dinPin,
    input  wire logic doutOut,
    input  wire logic doutOe
);
    initial begin
        sclkPin = 1'b1;
        csPinN  = 1'b1;
        dinPin  = 1'b0;
    end

    task automatic waitHalf();
        repeat (HALF) @(negedge core_clk);
    endtask

    // Data is set with the fall and taken by the device at the rise.
    task automatic bitCycle(input logic b, output logic seen);
        sclkPin = 1'b0;
        dinPin  = b;
        waitHalf();
        seen    = doutOe & doutOut;
        sclkPin = 1'b1;
        waitHalf();
    endtask

    task automatic frame(input logic rd, input logic [2:0] addr, input logic [15:0] wdata,
                         input logic holdCs, output logic [15:0] rdata);
        logic [7:0] cmd;
        logic       seen;
        int         nbits;
        cmd   = {1'b0, rd, addr, 3'b000};
        nbits = (addr == 3'h2 || (addr[2] && addr != 3'h5)) ? 16 : 8;
        rdata = '0;
        if (csPinN) begin
            csPinN = 1'b0;
            waitHalf();
        end
        for (int i = 7; i >= 0; i--) begin
            bitCycle(cmd[i], seen);
        end
        for (int i = nbits - 1; i >= 0; i--) begin
            bitCycle(wdata[i] & !rd, seen);
            rdata[i] = seen;
        end
        if (!holdCs) begin
            csPinN = 1'b1;
            waitHalf();
        end
    endtask

    task automatic serialReset();
        logic seen;
        for (int i = 0; i < 32; i++) begin
            bitCycle(1'b1, seen);
        end
        dinPin = 1'b0;
        repeat (RESET_GAP) @(negedge core_clk);
    endtask
endmodule

// ===== verif/tb.sv
`timescale 1ns/100ps
module tb;
    localparam logic [7:0] IDENT = 8'h5a;  // Arbitrary identification value.
    localparam logic [15:0] CMP_TEMP [7] = '{16'h1a00, 16'h2100, 16'h1f00, 16'h1a00,
                                             16'h0400, 16'h0700, 16'h0800};
    localparam logic [6:0] CMP_EXP = 7'b0110110;

    logic        core_clk;
    logic        reset;
    logic        sclkPin;
    logic        csPinN;
    logic        dinPin;
    logic        doutOut;
    logic        doutOe;
    logic [15:0] measuredTemp;
    logic        tempValid;
    logic        limitAlertOe;
    logic        criticalAlertPinOe;
    logic [15:0] rd;
    int          errors = 0;
    int          n_checks = 0;
    int          cycles = 0;

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    tsa_spi_master_model i_tsa_spi_master_model (.core_clk(core_clk), .sclkPin(sclkPin),
        .csPinN(csPinN), .dinPin(dinPin), .doutOut(doutOut), .doutOe(doutOe));

    // Pins are pulled up, so the readback is low only while pulled.
    tsa_temp_sensor_port #(.IDENT_VALUE(IDENT)) i_tsa_temp_sensor_port (
        .core_clk(core_clk), .reset(reset), .sclkPin(sclkPin), .csPinN(csPinN),
        .dinPin(dinPin), .doutOut(doutOut), .doutOe(doutOe), .measuredTemp(measuredTemp),
        .tempValid(tempValid), .limitAlertIn(!limitAlertOe), .limitAlertOut(),
        .limitAlertOe(limitAlertOe), .criticalAlertPinIn(!criticalAlertPinOe),
        .criticalAlertPinOut(), .criticalAlertPinOe(criticalAlertPinOe));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chkPin(input string what, input logic exp, input logic got);
        chk(what, {15'h0000, exp}, {15'h0000, got});
    endtask

    task automatic regWrite(input logic [2:0] a, input logic [15:0] d);
        i_tsa_spi_master_model.frame(1'b0, a, d, 1'b0, rd);
        repeat (8) @(negedge core_clk);
    endtask

    task automatic regRead(input logic [2:0] a, input logic [15:0] exp, input string what);
        i_tsa_spi_master_model.frame(1'b1, a, 16'h0000, 1'b0, rd);
        chk(what, exp, rd);
    endtask

    task automatic sample(input logic [15:0] t);
        measuredTemp = t;
        tempValid    = 1'b1;
        @(negedge core_clk);
        tempValid    = 1'b0;
        repeat (4) @(negedge core_clk);
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            errors++;
            conclude();
        end
    end

    initial begin
        reset        = 1'b1;
        measuredTemp = 16'h0000;
        tempValid    = 1'b0;
        repeat (16) @(negedge core_clk);
        reset = 1'b0;
        repeat (4) @(negedge core_clk);
        regRead(tsa_pkg::REG_IDENT, {8'h00, IDENT}, "ident");
        regRead(tsa_pkg::REG_CONFIG, 16'h0000, "config default");
        regRead(tsa_pkg::REG_CRIT, 16'h4980, "crit default");
        regRead(tsa_pkg::REG_HYST, 16'h0005, "hyst default");
        regRead(tsa_pkg::REG_UPPER, 16'h2000, "upper default");
        regRead(tsa_pkg::REG_LOWER, 16'h0500, "lower default");
        regWrite(tsa_pkg::REG_UPPER, 16'h1234);
        regWrite(tsa_pkg::REG_IDENT, 16'h00ff);
        regRead(tsa_pkg::REG_UPPER, 16'h1234, "upper written");
        regRead(tsa_pkg::REG_IDENT, {8'h00, IDENT}, "ident read only");
        regWrite(tsa_pkg::REG_LOWER, 16'h0300);
        regRead(tsa_pkg::REG_LOWER, 16'h0300, "lower written");
        // Back to back frames with select held low, as in three-wire use.
        i_tsa_spi_master_model.frame(1'b0, tsa_pkg::REG_HYST, 16'h000f, 1'b1, rd);
        i_tsa_spi_master_model.frame(1'b1, tsa_pkg::REG_HYST, 16'h0000, 1'b0, rd);
        chk("hyst three wire", 16'h000f, rd);
        i_tsa_spi_master_model.serialReset();
        regRead(tsa_pkg::REG_UPPER, 16'h2000, "upper after serial reset");
        regRead(tsa_pkg::REG_LOWER, 16'h0500, "lower after serial reset");
        regRead(tsa_pkg::REG_HYST, 16'h0005, "hyst after serial reset");
        sample(16'h2100);
        chkPin("limit set", 1'b1, limitAlertOe);
        regRead(tsa_pkg::REG_TEMP, 16'h2100, "temp value");
        chkPin("limit read clear", 1'b0, limitAlertOe);
        sample(16'h2100);
        chkPin("limit no rearm", 1'b0, limitAlertOe);
        sample(16'h1a00);
        sample(16'h2100);
        chkPin("limit rearmed", 1'b1, limitAlertOe);
        regWrite(tsa_pkg::REG_CONFIG, 16'h0020);
        chkPin("limit shutdown clear", 1'b0, limitAlertOe);
        regWrite(tsa_pkg::REG_CONFIG, 16'h0010);
        foreach (CMP_TEMP[i]) begin
            sample(CMP_TEMP[i]);
            chkPin("comparator", CMP_EXP[6 - i], limitAlertOe);
        end
        sample(16'h2100);
        regRead(tsa_pkg::REG_CONFIG, 16'h0010, "config mode");
        chkPin("comparator read keeps", 1'b1, limitAlertOe);
        regWrite(tsa_pkg::REG_CONFIG, 16'h0030);
        sample(16'h1a00);
        chkPin("comparator shutdown keeps", 1'b1, limitAlertOe);
        regWrite(tsa_pkg::REG_CONFIG, 16'h0010);
        sample(16'h4a00);
        chkPin("crit set", 1'b1, criticalAlertPinOe);
        regRead(tsa_pkg::REG_STATUS, 16'h0003, "status both");
        regWrite(tsa_pkg::REG_CONFIG, 16'h001c);
        chkPin("crit active high", 1'b0, criticalAlertPinOe);
        chkPin("limit active high", 1'b0, limitAlertOe);
        // Inside the band: below the critical limit, above its release point.
        sample(16'h4800);
        chkPin("crit band hold", 1'b0, criticalAlertPinOe);
        sample(16'h4500);
        chkPin("crit released", 1'b1, criticalAlertPinOe);
        conclude();
    end
endmodule

bind tsa_temp_sensor_port tsa_temp_sensor_port_properties i_tsa_temp_sensor_port_properties (
    .core_clk(core_clk), .reset(reset), .sclkPin(sclkPin), .csPinN(csPinN),
    .doutOut(doutOut), .doutOe(doutOe), .tempValid(tempValid),
    .limitAlertOut(limitAlertOut), .limitAlertOe(limitAlertOe),
    .criticalAlertPinOut(criticalAlertPinOut), .criticalAlertPinOe(criticalAlertPinOe));
